//--- hw/pft_pkg.sv
package pft_pkg;

  // Clock and timer widths
  localparam longint CLK_HZ    = 100_000_000;
  localparam int     TMR_W     = 40;
  localparam int     LIM_W     = 24;
  localparam int     CNT_W     = 16;
  localparam int     NUM_ATTR  = 4;

  // Periods in their own units, with derived cycle counts
  localparam longint SCHED_PERIOD_S  = 7200;
  localparam longint TEMP_PERIOD_S   = 600;
  localparam longint DELAY_ONLINE_MS = 42;
  localparam longint DELAY_FULL_MS   = 163;
  localparam longint SCHED_CYCLES    = SCHED_PERIOD_S * CLK_HZ;
  localparam longint TEMP_CYCLES     = TEMP_PERIOD_S * CLK_HZ;
  localparam longint ONLINE_LIMIT    = (DELAY_ONLINE_MS * CLK_HZ) / 1000;
  localparam longint FULL_LIMIT      = (DELAY_FULL_MS * CLK_HZ) / 1000;

  // Register byte addresses
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_REFTEMP = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;
  localparam logic [7:0] REG_TIME_LO = 8'h0C;
  localparam logic [7:0] REG_TIME_HI = 8'h10;

  // Control field positions
  localparam int CTRL_DISABLE_BIT = 0;
  localparam int CTRL_ONLINE_BIT  = 1;
  localparam int CTRL_TWARN_BIT   = 2;
  localparam int CTRL_METHOD_LSB  = 4;
  localparam int CTRL_METHOD_W    = 4;

  // Status field positions
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_PF_BIT     = 1;
  localparam int ST_TWARN_BIT  = 2;
  localparam int ST_ROUND_BIT  = 3;
  localparam int ST_TEMP_LSB   = 8;
  localparam int ST_PFATTR_LSB = 16;

  // Reset values
  localparam logic [CTRL_METHOD_W-1:0] METHOD_RESET = 4'h0;
  localparam logic [CTRL_METHOD_W-1:0] METHOD_NONE  = 4'h0;
  localparam logic [7:0]               TEMP_MAX     = 8'h44;

  // Sense codes
  localparam logic [7:0] SENSE_KEY_INFO = 8'h01;
  localparam logic [7:0] ASC_PREDICT    = 8'h5D;
  localparam logic [7:0] ASC_TEMP       = 8'h0B;
  localparam logic [7:0] ASCQ_TEMP      = 8'h01;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MEAS = 3'b010,
    ST_SAVE = 3'b100
  } pft_state_type;

endpackage : pft_pkg

//--- hw/pft_timer.sv
`timescale 1ns/1ps

module pft_timer #(
  parameter int W = 40
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic [W-1:0] period,
  input  wire logic         run,
  input  wire logic         restart,
  output logic              tick,
  output logic [W-1:0]      remaining
);
  import pft_pkg::*;

  logic [W-1:0] remain_reg;

  // Count hits zero at reset, so a freshly released timer ticks at once
  assign tick      = run && !restart && (remain_reg == '0);
  assign remaining = remain_reg;

  // Down counter reloads on restart and on every tick
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      remain_reg <= '0;
    end else if (restart || tick) begin
      remain_reg <= period - W'(1);
    end else if (run) begin
      remain_reg <= remain_reg - W'(1);
    end
  end

endmodule : pft_timer

//--- hw/pft_attr.sv
`timescale 1ns/1ps

module pft_attr #(
  parameter int                      CW          = 16,
  parameter logic [CW-1:0]           WINDOW_LEN  = 16'h0064,
  parameter logic [CW-1:0]           ERR_THRESH  = 16'h0004,
  parameter logic [CW-1:0]           PRED_THRESH = 16'h0008
) (
  input  wire logic          clk_sys,
  input  wire logic          resetn,
  input  wire logic          enable,
  input  wire logic          op,
  input  wire logic          err,
  output logic               pred_fail,
  output logic [CW-1:0]      history
);
  import pft_pkg::*;

  logic [CW-1:0] win_len_reg;
  logic [CW-1:0] err_thr_reg;
  logic [CW-1:0] pred_thr_reg;
  logic [CW-1:0] interval_reg;
  logic [CW-1:0] fail_reg;
  logic [CW-1:0] hist_reg;
  logic          bad_reg;
  logic          win_end;
  logic [CW-1:0] fail_next;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      win_len_reg  <= WINDOW_LEN;
      err_thr_reg  <= ERR_THRESH;
      pred_thr_reg <= PRED_THRESH;
    end
  end

  assign win_end   = enable && op && (interval_reg >= win_len_reg - CW'(1));
  assign fail_next = (err && fail_reg != '1) ? fail_reg + CW'(1) : fail_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      interval_reg <= '0;
      fail_reg     <= '0;
      bad_reg      <= 1'b0;
    end else if (win_end) begin
      interval_reg <= '0;
      fail_reg     <= '0;
      bad_reg      <= 1'b0;
    end else if (enable) begin
      if (op) begin
        interval_reg <= interval_reg + CW'(1);
      end
      fail_reg <= fail_next;
      if (fail_next > err_thr_reg) begin
        bad_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hist_reg <= '0;
    end else if (win_end) begin
      if (bad_reg || fail_next > err_thr_reg) begin
        if (hist_reg != '1) hist_reg <= hist_reg + CW'(1);
      end else if (hist_reg != '0) begin
        hist_reg <= hist_reg - CW'(1);
      end
    end
  end

  assign pred_fail = (hist_reg >= pred_thr_reg);
  assign history   = hist_reg;

endmodule : pft_attr

//--- hw/pft_monitor.sv
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps

// Functional notes
// - Disable bit stops scheduling, measurement and attribute monitoring; temperature sampling and warnings go on.
// - Online-only bit skips every off-line measurement.
// - Enabled monitor gathers attribute data during media reads and writes.
// - Scheduled measurement every two hours, deferred until host bus idle.
// - Rezero forces immediate measure and save and restarts schedule timer.
// - Time left to next scheduled measurement is readable by host.
// - Measurement and save, once started, runs until done or until the delay limit ends it.
// - Processing delay at most 42 ms online-only, 163 ms fully enabled.
// - Predictive failure reported with 01-5Dxx via chosen reporting method.
// - Reported failure code survives bus resets and power cycles.
// - Interval counter per attribute; interval length sets window size.
// - Failure counter per attribute counts errors in current window.
// - Window unacceptable when errors pass threshold, else acceptable.
// - Window end clears interval and failure counters.
// - History counter up on bad window, down on good, floor zero.
// - Predictive failure when history reaches predictive threshold.
// - Temperature sampled at power-up, then every ten minutes.
// - Temperature above active trip point raises 01-0B01 warning.
// - Measured temperature placed in FRU field of sense data.
// - Temperature warnings gated by enable bit, delivered per method.
// - Fixed trip at 68; exceeding it also stores a data frame (none while the disable bit is set).
// - Host-set second trip, default 68, clamped to 68 with flag.
module pft_monitor #(
  parameter int                        N_ATTR         = pft_pkg::NUM_ATTR,
  parameter logic [pft_pkg::TMR_W-1:0] SCHED_PERIOD   = pft_pkg::TMR_W'(pft_pkg::SCHED_CYCLES),
  parameter logic [pft_pkg::TMR_W-1:0] TEMP_PERIOD    = pft_pkg::TMR_W'(pft_pkg::TEMP_CYCLES),
  parameter logic [pft_pkg::LIM_W-1:0] ONLINE_LIMIT   = pft_pkg::LIM_W'(pft_pkg::ONLINE_LIMIT),
  parameter logic [pft_pkg::LIM_W-1:0] FULL_LIMIT     = pft_pkg::LIM_W'(pft_pkg::FULL_LIMIT)
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  input  wire logic [N_ATTR-1:0] media_op,
  input  wire logic [N_ATTR-1:0] media_err,
  input  wire logic              bus_idle,
  input  wire logic              bus_reset,
  input  wire logic              rezero_cmd,
  output logic                   meas_start,
  input  wire logic              meas_done,
  output logic                   save_req,
  input  wire logic              save_done,
  output logic                   host_hold,
  input  wire logic [7:0]        temp_in,
  output logic                   frame_save,
  input  wire logic              nv_code_valid,
  input  wire logic [7:0]        nv_code_attr,
  output logic                   nv_code_store,
  output logic                   excpt_valid,
  output logic [3:0]             excpt_method,
  output logic [7:0]             excpt_key,
  output logic [7:0]             excpt_asc,
  output logic [7:0]             excpt_ascq,
  output logic [7:0]             excpt_fru
);
  import pft_pkg::*;

  // Control fields
  logic                     monitor_disable;
  logic                     online_only_select;
  logic                     temp_warning_enable;
  logic [CTRL_METHOD_W-1:0] report_method;
  logic [7:0]               ref_temp_reg;
  logic                     round_reg;
  logic                     enable;

  // Measurement sequencer
  pft_state_type            state_reg;
  pft_state_type            state_next;
  logic [LIM_W-1:0]         lim_reg;
  logic                     sched_pend_reg;
  logic                     start_meas;
  logic                     lim_hit;
  logic                     init_reg;

  // Timers and attributes
  logic                     sched_tick;
  logic                     temp_tick;
  logic [TMR_W-1:0]         sched_remain;
  logic [N_ATTR-1:0]        attr_fail;

  // Predictive failure and temperature state
  logic                     pf_reg;
  logic [7:0]               pf_attr_reg;
  logic                     pf_new;
  logic [7:0]               pf_new_attr;
  logic [7:0]               temp_reg;
  logic                     temp_chk_reg;
  logic                     twarn_reg;
  logic                     trip_hi;
  logic                     trip_ref;
  logic                     pf_pend_reg;
  logic                     tw_pend_reg;
  logic                     issue_pf;
  logic                     issue_tw;

  assign enable = !monitor_disable;

  // Control register; bus reset leaves settings alone
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      monitor_disable     <= 1'b0;
      online_only_select  <= 1'b0;
      temp_warning_enable <= 1'b0;
      report_method       <= METHOD_RESET;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      monitor_disable     <= reg_wdata[CTRL_DISABLE_BIT];
      online_only_select  <= reg_wdata[CTRL_ONLINE_BIT];
      temp_warning_enable <= reg_wdata[CTRL_TWARN_BIT];
      report_method       <= reg_wdata[CTRL_METHOD_LSB +: CTRL_METHOD_W];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ref_temp_reg <= TEMP_MAX;
      round_reg    <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == REG_REFTEMP) begin
        ref_temp_reg <= (reg_wdata[7:0] > TEMP_MAX) ? TEMP_MAX : reg_wdata[7:0];
      end
      // Rounding flag clears on status read; a new clamp in that cycle wins
      if (reg_wr && reg_addr == REG_REFTEMP && reg_wdata[7:0] > TEMP_MAX) begin
        round_reg <= 1'b1;
      end else if (reg_rd && reg_addr == REG_STATUS) begin
        round_reg <= 1'b0;
      end
    end
  end

  // First cycle after reset release, used to arm the schedule
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      init_reg <= 1'b1;
    end else begin
      init_reg <= 1'b0;
    end
  end

  pft_timer #(
    .W         (TMR_W)
  ) u_sched_timer (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .period    (SCHED_PERIOD),
    .run       (enable),
    .restart   (init_reg || (start_meas && rezero_cmd)),
    .tick      (sched_tick),
    .remaining (sched_remain)
  );

  pft_timer #(
    .W         (TMR_W)
  ) u_temp_timer (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .period    (TEMP_PERIOD),
    .run       (1'b1),
    .restart   (1'b0),
    .tick      (temp_tick),
    .remaining ()
  );

  // per-attribute trackers fed from media traffic
  for (genvar i = 0; i < N_ATTR; i++) begin : g_attr
    pft_attr #(
      .CW          (CNT_W)
    ) u_attr (
      .clk_sys     (clk_sys),
      .resetn      (resetn),
      .enable      (enable),
      .op          (media_op[i]),
      .err         (media_err[i]),
      .pred_fail   (attr_fail[i]),
      .history     ()
    );
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sched_pend_reg <= 1'b0;
    end else if (!enable) begin
      sched_pend_reg <= 1'b0;
    end else if (sched_tick) begin
      sched_pend_reg <= 1'b1;
    end else if (start_meas) begin
      sched_pend_reg <= 1'b0;
    end
  end

  assign start_meas = enable && (state_reg == ST_IDLE)
                      && (rezero_cmd || (sched_pend_reg && bus_idle));

  assign lim_hit = (lim_reg >= (online_only_select ? ONLINE_LIMIT : FULL_LIMIT) - LIM_W'(1));

  // Sequencer next state; the delay bound wins over a slow media side
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start_meas) state_next = online_only_select ? ST_SAVE : ST_MEAS;
      end
      ST_MEAS: begin
        if (lim_hit) state_next = ST_IDLE;
        else if (meas_done) state_next = ST_SAVE;
      end
      ST_SAVE: begin
        if (save_done || lim_hit) state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      lim_reg   <= '0;
    end else begin
      state_reg <= state_next;
      lim_reg   <= (state_next == ST_IDLE) ? '0 : lim_reg + LIM_W'(1);
    end
  end

  // Sequencer outputs; host is held off for the whole measure and save
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meas_start <= 1'b0;
      save_req   <= 1'b0;
      host_hold  <= 1'b0;
    end else begin
      meas_start <= start_meas && !online_only_select;
      save_req   <= (state_next == ST_SAVE);
      host_hold  <= (state_next != ST_IDLE);
    end
  end

  // Lowest-numbered failing attribute is the one reported
  always_comb begin
    pf_new      = 1'b0;
    pf_new_attr = 8'h00;
    for (int k = N_ATTR - 1; k >= 0; k--) begin
      if (attr_fail[k]) begin
        pf_new      = enable && !pf_reg;
        pf_new_attr = 8'(k);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pf_reg        <= 1'b0;
      pf_attr_reg   <= 8'h00;
      nv_code_store <= 1'b0;
    end else begin
      nv_code_store <= pf_new;
      if (init_reg && nv_code_valid) begin
        pf_reg      <= 1'b1;
        pf_attr_reg <= nv_code_attr;
      end else if (pf_new) begin
        pf_reg      <= 1'b1;
        pf_attr_reg <= pf_new_attr;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      temp_reg     <= 8'h00;
      temp_chk_reg <= 1'b0;
    end else begin
      temp_chk_reg <= temp_tick;
      if (temp_tick) temp_reg <= temp_in;
    end
  end

  assign trip_hi  = temp_chk_reg && (temp_reg > TEMP_MAX);
  assign trip_ref = temp_chk_reg && (temp_reg > ref_temp_reg);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      frame_save <= 1'b0;
      twarn_reg  <= 1'b0;
    end else begin
      frame_save <= trip_hi && enable;
      if (temp_chk_reg) twarn_reg <= trip_hi || trip_ref;
    end
  end

  // One report per cycle; predictive failure goes ahead of temperature
  assign issue_pf = pf_pend_reg && (report_method != METHOD_NONE);
  assign issue_tw = tw_pend_reg && !issue_pf && (report_method != METHOD_NONE);

  // Pending reports; a new event in the issuing cycle is kept
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pf_pend_reg <= 1'b0;
      tw_pend_reg <= 1'b0;
    end else begin
      pf_pend_reg <= (pf_pend_reg && !issue_pf) || pf_new || (init_reg && nv_code_valid);
      tw_pend_reg <= (tw_pend_reg && !issue_tw)
                     || ((trip_hi || trip_ref) && temp_warning_enable);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      excpt_valid  <= 1'b0;
      excpt_method <= METHOD_NONE;
      excpt_key    <= 8'h00;
      excpt_asc    <= 8'h00;
      excpt_ascq   <= 8'h00;
      excpt_fru    <= 8'h00;
    end else begin
      excpt_valid  <= issue_pf || issue_tw;
      excpt_method <= report_method;
      if (issue_pf) begin
        excpt_key  <= SENSE_KEY_INFO;
        excpt_asc  <= ASC_PREDICT;
        excpt_ascq <= pf_attr_reg;
        excpt_fru  <= 8'h00;
      end else if (issue_tw) begin
        excpt_key  <= SENSE_KEY_INFO;
        excpt_asc  <= ASC_TEMP;
        excpt_ascq <= ASCQ_TEMP;
        excpt_fru  <= temp_reg;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL:    reg_rdata <= {24'h00_0000, report_method, 1'b0, temp_warning_enable,
                                   online_only_select, monitor_disable};
        REG_REFTEMP: reg_rdata <= {24'h00_0000, ref_temp_reg};
        REG_STATUS:  reg_rdata <= {8'h00, pf_attr_reg, temp_reg, 4'h0, round_reg,
                                   twarn_reg, pf_reg, host_hold};
        REG_TIME_LO: reg_rdata <= sched_remain[31:0];
        REG_TIME_HI: reg_rdata <= {24'h00_0000, sched_remain[TMR_W-1:32]};
        default:     reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : pft_monitor

//--- tb/pft_monitor_checker.sv
`timescale 1ns/1ps

module pft_monitor_checker #(
  parameter logic [pft_pkg::LIM_W-1:0] FULL_LIMIT = pft_pkg::LIM_W'(pft_pkg::FULL_LIMIT)
) (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        meas_start,
  input wire logic        save_req,
  input wire logic        save_done,
  input wire logic        host_hold,
  input wire logic        frame_save,
  input wire logic        nv_code_store,
  input wire logic        excpt_valid,
  input wire logic [3:0]  excpt_method,
  input wire logic [7:0]  excpt_key,
  input wire logic [7:0]  excpt_asc,
  input wire logic [7:0]  excpt_ascq
);
  import pft_pkg::*;

  logic [23:0] hold_cnt_reg;

  // Cycles the current sequence has held the host; the limit must end it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) hold_cnt_reg <= 24'h0000;
    else if (host_hold) hold_cnt_reg <= hold_cnt_reg + 24'h0001;
    else hold_cnt_reg <= 24'h0000;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_save_fin;
    save_req && save_done;
  endsequence
  sequence s_release;
    !save_req && !host_hold;
  endsequence

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  a_start_hold: assert property (meas_start |-> host_hold ##1 !meas_start)
    else $error("measure start without hold");
  a_save_hold: assert property (save_req |-> host_hold)
    else $error("save request without hold");
  a_save_release: assert property (s_save_fin |=> s_release)
    else $error("sequence not released after save");
  a_seq_limit: assert property (hold_cnt_reg <= FULL_LIMIT + 24'h0002)
    else $error("sequence longer than limit");
  a_report_code: assert property (excpt_valid |-> excpt_key == 8'h01 &&
    (excpt_asc == 8'h5D || (excpt_asc == 8'h0B && excpt_ascq == 8'h01)))
    else $error("bad sense code");
  a_report_gate: assert property (excpt_valid |-> excpt_method != 4'h0)
    else $error("report with reporting off");
  a_frame_pulse: assert property (frame_save |=> !frame_save)
    else $error("frame save not a pulse");
  a_store_pulse: assert property (nv_code_store |=> !nv_code_store)
    else $error("code store not a pulse");
endmodule : pft_monitor_checker

bind pft_monitor pft_monitor_checker #(.FULL_LIMIT(FULL_LIMIT)) u_checker (
  .clk_sys(clk_sys), .resetn(resetn), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .meas_start(meas_start), .save_req(save_req), .save_done(save_done),
  .host_hold(host_hold), .frame_save(frame_save), .nv_code_store(nv_code_store),
  .excpt_valid(excpt_valid), .excpt_method(excpt_method), .excpt_key(excpt_key),
  .excpt_asc(excpt_asc), .excpt_ascq(excpt_ascq)
);

//--- tb/pft_media_model.sv
`timescale 1ns/1ps

module pft_media_model (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic [7:0] delay,
  input  wire logic       meas_start,
  input  wire logic       save_req,
  output logic            meas_done,
  output logic            save_done
);
  logic [7:0] m_cnt_reg;
  logic [7:0] s_cnt_reg;

  // Measurement answers delay cycles after start; a slow delay outlasts the limit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      m_cnt_reg <= 8'h00;
      meas_done <= 1'b0;
    end else begin
      meas_done <= (m_cnt_reg == 8'h01);
      if (meas_start) m_cnt_reg <= delay;
      else if (m_cnt_reg != 8'h00) m_cnt_reg <= m_cnt_reg - 8'h01;
    end
  end

  // Save done is one pulse after delay cycles of request
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_cnt_reg <= 8'h00;
      save_done <= 1'b0;
    end else begin
      save_done <= save_req && !save_done && (s_cnt_reg == delay);
      s_cnt_reg <= (save_req && !save_done) ? s_cnt_reg + 8'h01 : 8'h00;
    end
  end
endmodule : pft_media_model

//--- tb/pft_monitor_tb_top.sv
`timescale 1ns/1ps

module pft_monitor_tb_top;
  import pft_pkg::*;
  logic        clk_sys, resetn, reg_wr, reg_rd, bus_idle, bus_reset, rezero_cmd;
  logic        nv_code_valid, meas_start, meas_done, save_req, save_done, host_hold;
  logic        frame_save, nv_code_store, excpt_valid;
  logic [7:0]  reg_addr, temp_in, nv_code_attr, dly, excpt_key, excpt_asc, excpt_ascq, excpt_fru;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [3:0]  media_op, media_err, excpt_method;
  logic [15:0] pf_code;
  int          n_errors, checks, seed, i, n, h, n_store, n_frame;
  bit          st;
  bit          pat [11] = '{0, 1, 1, 1, 1, 1, 1, 1, 0, 1, 1};

  pft_monitor #(.SCHED_PERIOD(40'h00c8), .TEMP_PERIOD(40'h0064), .ONLINE_LIMIT(24'h0014),
    .FULL_LIMIT(24'h0032)) u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .media_op(media_op),
    .media_err(media_err), .bus_idle(bus_idle), .bus_reset(bus_reset),
    .rezero_cmd(rezero_cmd), .meas_start(meas_start), .meas_done(meas_done),
    .save_req(save_req), .save_done(save_done), .host_hold(host_hold), .temp_in(temp_in),
    .frame_save(frame_save), .nv_code_valid(nv_code_valid), .nv_code_attr(nv_code_attr),
    .nv_code_store(nv_code_store), .excpt_valid(excpt_valid), .excpt_method(excpt_method),
    .excpt_key(excpt_key), .excpt_asc(excpt_asc), .excpt_ascq(excpt_ascq),
    .excpt_fru(excpt_fru));

  pft_media_model u_media (.clk_sys(clk_sys), .resetn(resetn), .delay(dly),
    .meas_start(meas_start), .save_req(save_req), .meas_done(meas_done),
    .save_done(save_done));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Tallies of pulses that are too short to catch from the main sequence
  always @(posedge clk_sys) begin
    if (nv_code_store === 1'b1) n_store++;
    if (frame_save === 1'b1) n_frame++;
    if (excpt_valid === 1'b1 && excpt_asc === 8'h5D) pf_code = {excpt_key, excpt_ascq};
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  // Rezero while idle, then count the cycles the sequence holds the host
  task automatic rezero_run(output int cnt, output bit seen);
    cnt = 0;
    seen = 0;
    while (host_hold === 1'b1) @(posedge clk_sys);
    @(posedge clk_sys);
    rezero_cmd <= 1'b1;
    @(posedge clk_sys);
    rezero_cmd <= 1'b0;
    #1;
    while (host_hold === 1'b1 && cnt < 300) begin
      seen |= (meas_start === 1'b1);
      cnt++;
      @(posedge clk_sys);
      #1;
    end
  endtask : rezero_run

  task automatic wait_rep(input logic [7:0] a);
    for (i = 0; i < 250 && !(excpt_valid === 1'b1 && excpt_asc === a); i++) @(posedge clk_sys);
  endtask : wait_rep

  // One window of 100 ops on attribute 0; the others see random error-free ops
  task automatic window(input int nerr);
    for (int k = 0; k < 100; k++) begin
      @(posedge clk_sys);
      media_op <= {3'($random(seed)), 1'b1};
      media_err <= {3'b000, k < nerr};
      bus_idle <= 1'($random(seed));
      @(posedge clk_sys);
      media_op <= 4'h0;
      media_err <= 4'h0;
    end
  endtask : window

  function automatic int hist_next(input int hv, input bit bad);
    return bad ? hv + 1 : (hv > 0 ? hv - 1 : 0);
  endfunction : hist_next

  task automatic conclude;
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  initial begin
    #300_000;
    n_errors++;
    conclude;
  end

  initial begin
    seed = 31;
    {resetn, reg_wr, reg_rd, bus_idle, bus_reset, rezero_cmd, nv_code_valid} = 7'h00;
    {reg_addr, reg_wdata, media_op, media_err, nv_code_attr} = '0;
    temp_in = 8'h20;
    dly = 8'h03;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    // Reset values, the power-up sample and an unmapped place
    rd(REG_CTRL, d);
    chk(d, 32'h0000_0000);
    rd(REG_REFTEMP, d);
    chk(d, 32'h0000_0044);
    rd(REG_STATUS, d);
    chk(d[15:8], 8'h20);
    rd(8'h20, d);
    chk(d, 32'h0000_0000);
    // Clamp above the fixed trip; the flag clears on the read that shows it
    wr(REG_REFTEMP, 32'h0000_0050);
    rd(REG_REFTEMP, d);
    chk(d, 32'h0000_0044);
    rd(REG_STATUS, d);
    chk(d[3], 1'b1);
    rd(REG_STATUS, d);
    chk(d[3], 1'b0);
    // Forced sequence restarts the schedule
    rezero_run(n, st);
    chk(st, 1'b1);
    rd(REG_TIME_LO, d);
    chk(d <= 200 && d + n + 8 >= 200, 1'b1);
    rd(REG_TIME_HI, d);
    chk(d, 32'h0000_0000);
    // Slow media side: the limit of online-only and full mode ends the sequence; disabled starts none
    dly <= 8'hc8;
    wr(REG_CTRL, 32'h0000_0002);
    rezero_run(n, st);
    chk(st, 1'b0);
    chk(n > 0 && n <= 22, 1'b1);
    wr(REG_CTRL, 32'h0000_0000);
    rezero_run(n, st);
    chk(n > 20 && n <= 52, 1'b1);
    wr(REG_CTRL, 32'h0000_0001);
    rezero_run(n, st);
    chk(n, 0);
    dly <= 8'h03;
    // Reading equal to the fixed trip but over the user trip
    wr(REG_REFTEMP, 32'h0000_0030);
    wr(REG_CTRL, 32'h0000_0010);
    temp_in <= 8'h44;
    wait_rep(8'h0B);
    chk(i, 250);
    wr(REG_CTRL, 32'h0000_0014);
    wait_rep(8'h0B);
    chk({excpt_key, excpt_ascq, excpt_fru}, 24'h01_0144);
    chk(n_frame, 0);
    temp_in <= 8'h45;
    repeat (220) @(posedge clk_sys);
    chk(n_frame > 0, 1'b1);
    // Four errors is an acceptable window, five is not
    temp_in <= 8'h20;
    wr(REG_CTRL, 32'h0000_0010);
    h = 0;
    foreach (pat[j]) begin
      window(pat[j] ? 5 : 4);
      h = hist_next(h, pat[j]);
      repeat (4) @(posedge clk_sys);
      chk(n_store, h >= 8);
    end
    bus_idle <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk(pf_code, 16'h0100);
    // Failure code survives a bus reset and a power cycle
    bus_reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus_reset <= 1'b0;
    rd(REG_STATUS, d);
    chk({d[23:16], d[1]}, 9'h001);
    @(posedge clk_sys);
    resetn <= 1'b0;
    nv_code_valid <= 1'b1;
    nv_code_attr <= 8'h02;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(REG_STATUS, d);
    chk({d[23:16], d[1]}, 9'h005);
    // Restored code stays pending while reporting is off
    wait_rep(8'h5D);
    chk(i, 250);
    conclude;
  end
endmodule : pft_monitor_tb_top
